//--- core/sidr_consts.svh
// constants for the identity readback spi block
`ifndef SIDR_CONSTS_SVH
`define SIDR_CONSTS_SVH

`define SIDR_WORD_W        16
`define SIDR_CNT_W         5
`define SIDR_PAR_BIT       13
`define SIDR_CMD_MASK      16'hDFFF
`define SIDR_CMD_IDENT     16'hCC00
`define SIDR_HDR_IDENT     16'hCC00
`define SIDR_ERR_WORD      16'hD000
`define SIDR_ID_LSB        6
`define SIDR_REV_LSB       0
`define SIDR_ID_RST        4'h5  // arbitrary value
`define SIDR_REV_RST       6'h01 // arbitrary value
`define SIDR_CNT_BAD       5'h11
`define SIDR_CTRL_EN_BIT   0

`define SIDR_ADDR_W        4
`define SIDR_OFF_CTRL      4'h0
`define SIDR_OFF_IDENT     4'h4
`define SIDR_OFF_STAT      4'h8
`define SIDR_OFF_LAST      4'hC
`define SIDR_RESP_OKAY     2'h0
`define SIDR_RESP_SLVERR   2'h2
`define SIDR_CTRL_RST      32'h0000_0001

`endif

//--- core/sidr_pkg.sv
// types for the identity readback spi block
package sidr_pkg;

    typedef enum logic [1:0] {
        SIDR_IDLE = 2'h0,
        SIDR_SHIFT = 2'h1,
        SIDR_DONE = 2'h3
    } sidr_state_t;

    typedef logic [15:0] sidr_word_t;

endpackage

//--- core/sidr_frame_if.sv
// carrier between the spi shifter and the decoder
`timescale 1ns/10ps
`default_nettype none

interface sidr_frame_if;
    logic [15:0] rx_word;
    logic        rx_done;
    logic [15:0] tx_word;

    modport shifter (
        output rx_word,
        output rx_done,
        input  tx_word
    );
    modport decoder (
        input  rx_word,
        input  rx_done,
        output tx_word
    );
endinterface

`default_nettype wire

//--- core/sidr_shifter.sv
// spi frame shifter, sclk and cs sampled on core clock
`timescale 1ns/10ps
`default_nettype none
`include "sidr_consts.svh"

module sidr_shifter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output var  logic       miso,
    sidr_frame_if.shifter   frm
);
    sidr_pkg::sidr_state_t state_q, state_d;
    logic [15:0]           rx_q, rx_d;
    logic [15:0]           tx_q, tx_d;
    logic [4:0]            cnt_q, cnt_d;
    logic                  sclk_q, sclk_d;
    logic                  done_q, done_d;
    logic                  miso_q, miso_d;
    logic                  rise;
    logic                  fall;

    assign rise        = sclk & ~sclk_q;
    assign fall        = ~sclk & sclk_q;
    assign frm.rx_word = rx_q;
    assign frm.rx_done = done_q;
    assign miso        = miso_q;

    always_comb begin
        state_d = state_q;
        rx_d    = rx_q;
        tx_d    = tx_q;
        cnt_d   = cnt_q;
        sclk_d  = sclk;
        done_d  = 1'b0;
        miso_d  = miso_q;
        case (state_q)
            sidr_pkg::SIDR_IDLE: begin
                if (!cs_n) begin
                    // load answer from the previous frame on cs fall
                    tx_d    = frm.tx_word;
                    miso_d  = frm.tx_word[`SIDR_WORD_W-1];
                    cnt_d   = '0;
                    state_d = sidr_pkg::SIDR_SHIFT;
                end
            end
            sidr_pkg::SIDR_SHIFT: begin
                if (cs_n) begin
                    // short frames are dropped, not decoded
                    state_d = sidr_pkg::SIDR_IDLE;
                end else begin
                    if (rise) begin
                        rx_d  = {rx_q[`SIDR_WORD_W-2:0], mosi};
                        cnt_d = cnt_q + 5'h01;
                    end
                    if (fall) begin
                        tx_d   = {tx_q[`SIDR_WORD_W-2:0], 1'b0};
                        miso_d = tx_q[`SIDR_WORD_W-2];
                    end
                    if (cnt_q == 5'(`SIDR_WORD_W)) begin
                        state_d = sidr_pkg::SIDR_DONE;
                    end
                end
            end
            sidr_pkg::SIDR_DONE: begin
                if (cs_n) begin
                    done_d  = 1'b1;
                    state_d = sidr_pkg::SIDR_IDLE;
                end else if (rise) begin
                    // extra clocks make the frame invalid
                    state_d = sidr_pkg::SIDR_SHIFT;
                    cnt_d   = `SIDR_CNT_BAD;
                end
            end
            default: state_d = sidr_pkg::SIDR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= sidr_pkg::SIDR_IDLE;
            rx_q    <= '0;
            tx_q    <= '0;
            cnt_q   <= '0;
            sclk_q  <= 1'b0;
            done_q  <= 1'b0;
            miso_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            rx_q    <= rx_d;
            tx_q    <= tx_d;
            cnt_q   <= cnt_d;
            sclk_q  <= sclk_d;
            done_q  <= done_d;
            miso_q  <= miso_d;
        end
    end
endmodule

`default_nettype wire

//--- core/sidr_axil.sv
// axi4-lite slave with control, identity and status words
`timescale 1ns/10ps
`default_nettype none
`include "sidr_consts.svh"

module sidr_axil (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    input  wire logic [31:0] stat_word,
    input  wire logic [31:0] last_word,
    output var  logic [31:0] ctrl_word,
    output var  logic [31:0] ident_word
);
    logic [3:0]  aw_q, aw_d;
    logic        awh_q, awh_d;
    logic [31:0] w_q, w_d;
    logic [3:0]  ws_q, ws_d;
    logic        wh_q, wh_d;
    logic [1:0]  br_q, br_d;
    logic        bv_q, bv_d;
    logic [31:0] rd_q, rd_d;
    logic [1:0]  rr_q, rr_d;
    logic        rv_q, rv_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] id_q, id_d;
    logic [31:0] cur;
    logic [31:0] merged;
    logic        awr_q, awr_d;
    logic        wr_q, wr_d;
    logic        arr_q, arr_d;

    // readies come from flops so no top output sees a gate
    assign awready    = awr_q;
    assign wready     = wr_q;
    assign arready    = arr_q;
    assign bresp      = br_q;
    assign bvalid     = bv_q;
    assign rdata      = rd_q;
    assign rresp      = rr_q;
    assign rvalid     = rv_q;
    assign ctrl_word  = ctrl_q;
    assign ident_word = id_q;

    always_comb begin
        aw_d = aw_q; awh_d = awh_q; w_d = w_q; ws_d = ws_q; wh_d = wh_q;
        br_d = br_q; bv_d = bv_q; rd_d = rd_q; rr_d = rr_q; rv_d = rv_q;
        ctrl_d = ctrl_q; id_d = id_q;
        cur = (aw_q == `SIDR_OFF_CTRL) ? ctrl_q : id_q;
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = ws_q[i] ? w_q[i*8 +: 8] : cur[i*8 +: 8];
        end
        if (awvalid && awready) begin
            aw_d = awaddr; awh_d = 1'b1;
        end
        if (wvalid && wready) begin
            w_d = wdata; ws_d = wstrb; wh_d = 1'b1;
        end
        if (awh_q && wh_q) begin
            awh_d = 1'b0; wh_d = 1'b0; bv_d = 1'b1;
            br_d  = `SIDR_RESP_OKAY;
            case (aw_q)
                `SIDR_OFF_CTRL:  ctrl_d = merged;
                `SIDR_OFF_IDENT: id_d = merged;
                `SIDR_OFF_STAT, `SIDR_OFF_LAST: ;
                default: br_d = `SIDR_RESP_SLVERR;
            endcase
        end
        if (bv_q && bready) bv_d = 1'b0;
        if (rv_q && rready) rv_d = 1'b0;
        if (arvalid && arready) begin
            rv_d = 1'b1;
            rr_d = `SIDR_RESP_OKAY;
            case (araddr)
                `SIDR_OFF_CTRL:  rd_d = ctrl_q;
                `SIDR_OFF_IDENT: rd_d = id_q;
                `SIDR_OFF_STAT:  rd_d = stat_word;
                `SIDR_OFF_LAST:  rd_d = last_word;
                default: begin
                    rd_d = '0;
                    rr_d = `SIDR_RESP_SLVERR;
                end
            endcase
        end
        awr_d = ~awh_d & ~bv_d;
        wr_d  = ~wh_d & ~bv_d;
        arr_d = ~rv_d;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_q <= '0; awh_q <= 1'b0; w_q <= '0; ws_q <= '0; wh_q <= 1'b0;
            br_q <= '0; bv_q <= 1'b0; rd_q <= '0; rr_q <= '0; rv_q <= 1'b0;
            ctrl_q <= `SIDR_CTRL_RST;
            awr_q  <= 1'b1;
            wr_q   <= 1'b1;
            arr_q  <= 1'b1;
            id_q   <= {22'h0, `SIDR_ID_RST, `SIDR_REV_RST};
        end else begin
            aw_q <= aw_d; awh_q <= awh_d; w_q <= w_d; ws_q <= ws_d; wh_q <= wh_d;
            br_q <= br_d; bv_q <= bv_d; rd_q <= rd_d; rr_q <= rr_d; rv_q <= rv_d;
            ctrl_q <= ctrl_d; id_q <= id_d;
            awr_q  <= awr_d;
            wr_q   <= wr_d;
            arr_q  <= arr_d;
        end
    end
endmodule

`default_nettype wire

//--- core/sidr_top.sv
// identity readback spi block with axi4-lite registers
// How it works
// RL1 - master sends 0xCC00 plus parity bit
// RL2 - bit 13 makes each word odd parity
// RL3 - response echoes mode bits 15,14,12..10
// RL4 - 4-bit device code in bits 9..6
// RL5 - 6-bit revision in bits 5..0
`timescale 1ns/10ps
`default_nettype none
`include "sidr_consts.svh"

module sidr_top (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        SPI_SCLK,
    input  wire logic        SPI_CS_N,
    input  wire logic        SPI_MOSI,
    output var  logic        SPI_MISO,
    input  wire logic [3:0]  AWADDR,
    input  wire logic        AWVALID,
    output var  logic        AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output var  logic        WREADY,
    output var  logic [1:0]  BRESP,
    output var  logic        BVALID,
    input  wire logic        BREADY,
    input  wire logic [3:0]  ARADDR,
    input  wire logic        ARVALID,
    output var  logic        ARREADY,
    output var  logic [31:0] RDATA,
    output var  logic [1:0]  RRESP,
    output var  logic        RVALID,
    input  wire logic        RREADY
);
    sidr_frame_if frm ();

    logic [31:0]        ctrl_word;
    logic [31:0]        ident_word;
    logic [3:0]         identity_field_bits;
    logic [5:0]         silicon_revision_bits;
    sidr_pkg::sidr_word_t body;
    sidr_pkg::sidr_word_t resp_q, resp_d;
    sidr_pkg::sidr_word_t last_q, last_d;
    logic [15:0]        cnt_ok_q, cnt_ok_d;
    logic [7:0]         cnt_err_q, cnt_err_d;
    logic               par_ok;
    logic               cmd_ok;

    sidr_shifter u_shift (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .sclk  (SPI_SCLK),
        .cs_n  (SPI_CS_N),
        .mosi  (SPI_MOSI),
        .miso  (SPI_MISO),
        .frm   (frm.shifter)
    );

    sidr_axil u_bus (
        .clk        (CORE_CLK),
        .rst_n      (RST_N),
        .awaddr     (AWADDR),
        .awvalid    (AWVALID),
        .awready    (AWREADY),
        .wdata      (WDATA),
        .wstrb      (WSTRB),
        .wvalid     (WVALID),
        .wready     (WREADY),
        .bresp      (BRESP),
        .bvalid     (BVALID),
        .bready     (BREADY),
        .araddr     (ARADDR),
        .arvalid    (ARVALID),
        .arready    (ARREADY),
        .rdata      (RDATA),
        .rresp      (RRESP),
        .rvalid     (RVALID),
        .rready     (RREADY),
        .stat_word  ({cnt_err_q, cnt_ok_q, 8'h00}),
        .last_word  ({16'h0000, last_q}),
        .ctrl_word  (ctrl_word),
        .ident_word (ident_word)
    );

    assign identity_field_bits   = ident_word[`SIDR_ID_LSB +: 4];
    assign silicon_revision_bits = ident_word[`SIDR_REV_LSB +: 6];
    assign frm.tx_word           = resp_q;

    // odd parity over all sixteen bits means xor of the word is one
    assign par_ok = ^frm.rx_word; // RL2
    assign cmd_ok = (frm.rx_word & `SIDR_CMD_MASK) == `SIDR_CMD_IDENT; // RL1

    always_comb begin
        body = `SIDR_HDR_IDENT; // RL3
        body[`SIDR_ID_LSB +: 4]  = identity_field_bits; // RL4
        body[`SIDR_REV_LSB +: 6] = silicon_revision_bits; // RL5
        body[`SIDR_PAR_BIT] = ~^body; // RL2
        resp_d    = resp_q;
        last_d    = last_q;
        cnt_ok_d  = cnt_ok_q;
        cnt_err_d = cnt_err_q;
        if (frm.rx_done) begin
            last_d = frm.rx_word;
            // bad parity or foreign command answers the error word next frame
            if (par_ok && cmd_ok && ctrl_word[`SIDR_CTRL_EN_BIT]) begin
                resp_d   = body;
                cnt_ok_d = cnt_ok_q + 16'h0001;
            end else begin
                resp_d    = `SIDR_ERR_WORD;
                cnt_err_d = cnt_err_q + 8'h01;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            resp_q    <= `SIDR_ERR_WORD;
            last_q    <= '0;
            cnt_ok_q  <= '0;
            cnt_err_q <= '0;
        end else begin
            resp_q    <= resp_d;
            last_q    <= last_d;
            cnt_ok_q  <= cnt_ok_d;
            cnt_err_q <= cnt_err_d;
        end
    end
endmodule

`default_nettype wire

//--- tb/sidr_checker.sv
// port assertions for the identity readback block
`timescale 1ns/10ps
`default_nettype none
`include "sidr_consts.svh"
module sidr_checker (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        SPI_SCLK,
    input wire logic        SPI_CS_N,
    input wire logic        SPI_MISO,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [1:0]  BRESP
);
    logic        sclk_q;
    logic        sclk_d;
    logic        cs_q;
    logic        cs_d;
    logic [15:0] sh_q;
    logic [15:0] sh_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic        done;
    // collects miso at each sclk rise, as the controller would
    always_comb begin
        sclk_d = SPI_SCLK;
        cs_d   = SPI_CS_N;
        sh_d   = sh_q;
        cnt_d  = SPI_CS_N ? 5'h00 : cnt_q;
        if (!SPI_CS_N && SPI_SCLK && !sclk_q) begin
            sh_d  = {sh_q[14:0], SPI_MISO};
            cnt_d = cnt_q + 5'h01;
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
            sh_q   <= 16'h0000;
            cnt_q  <= 5'h00;
        end else begin
            sclk_q <= sclk_d;
            cs_q   <= cs_d;
            sh_q   <= sh_d;
            cnt_q  <= cnt_d;
        end
    end
    // short frames are not judged: the device ignores them
    assign done = SPI_CS_N && !cs_q && (cnt_q == 5'h10);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    a_resp_odd_parity: assert property (done |-> ^sh_q)
        else $error("response word has even parity");
    a_resp_mode_bits: assert property (done |-> ((sh_q & 16'hDC00) == 16'hCC00)
        || (sh_q == `SIDR_ERR_WORD)) else $error("response mode bits wrong");
    a_read_next_cycle: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data not one cycle after address");
    a_read_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read answer dropped before taken");
    a_write_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped before taken");
    c_frame: cover property (done);
    c_write: cover property (BVALID && BREADY);
    c_slverr: cover property (RVALID && RREADY && RRESP == `SIDR_RESP_SLVERR);
    c_read_wait: cover property (RVALID && !RREADY);
endmodule
bind sidr_top sidr_checker u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .SPI_SCLK(SPI_SCLK),
    .SPI_CS_N(SPI_CS_N), .SPI_MISO(SPI_MISO), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP));
`default_nettype wire

//--- tb/sidr_spi_master.sv
// spi master model standing in for the controller
`timescale 1ns/10ps
`default_nettype none
module sidr_spi_master (
    input  wire logic clk,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    function automatic logic [15:0] odd_par(input logic [15:0] w);
        return {w[15:14], ~^{w[15:14], w[12:0]}, w[12:0]};
    endfunction
    // hp is the sclk half period in core clocks: fast and slow masters
    task automatic xfer(input logic [15:0] w, input bit good, input int n, input int hp,
                        output logic [15:0] rx);
        logic [15:0] tx;
        tx = odd_par(w);
        tx[13] = tx[13] ^ !good;
        rx = 16'h0000;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (hp + 2) @(posedge clk);
        for (int i = 15; i > 15 - n; i--) begin
            mosi <= tx[i];
            repeat (hp) @(posedge clk);
            sclk <= 1'b1;
            rx = {rx[14:0], miso};
            repeat (hp) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (hp) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~tx[16 - n]; // released line must not look like the last bit
        repeat (hp) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the identity readback block
`timescale 1ns/10ps
`default_nettype none
`include "sidr_consts.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic        CORE_CLK, RST_N, SPI_SCLK, SPI_CS_N, SPI_MOSI, SPI_MISO;
    logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic        ARVALID, ARREADY, RVALID, RREADY, en, lag;
    logic [3:0]  AWADDR, WSTRB, ARADDR, cur_id;
    logic [31:0] WDATA, RDATA, rd;
    logic [1:0]  BRESP, RRESP, rs;
    logic [15:0] next_rsp, rx;
    logic [5:0]  cur_rev;
    int          failures, tests_run, n_ok, n_err;
    localparam logic [15:0] CMD = `SIDR_CMD_IDENT;
    localparam logic [31:0] VALS [3] = '{32'h3FF, 32'h000, 32'h295};
    sidr_top DUT (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .SPI_SCLK(SPI_SCLK),
        .SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY));
    sidr_spi_master u_master (.clk(CORE_CLK), .sclk(SPI_SCLK), .cs_n(SPI_CS_N),
        .mosi(SPI_MOSI), .miso(SPI_MISO));
    always #2 CORE_CLK = ~CORE_CLK;
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= ~lag;
        do begin
            @(posedge CORE_CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1 && BREADY !== 1'b1) BREADY <= 1'b1;
        end while (BVALID !== 1'b1 || BREADY !== 1'b1);
        rs = BRESP;
        BREADY <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        @(posedge CORE_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= ~lag;
        do begin
            @(posedge CORE_CLK);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1 && RREADY !== 1'b1) RREADY <= 1'b1;
        end while (RVALID !== 1'b1 || RREADY !== 1'b1);
        rd = RDATA;
        rs = RRESP;
        RREADY <= 1'b0;
    endtask
    // answer comes one frame late, so the bench keeps the pending word
    task automatic frame(input logic [15:0] w, input bit good, input int n, input int hp);
        logic [15:0] exp;
        exp = next_rsp;
        u_master.xfer(w, good, n, hp, rx);
        if (n == 16) begin
            `CHK("spi response", exp, rx)
            `CHK("response parity", 1'b1, ^rx)
            if (good && w == CMD && en) begin
                next_rsp = u_master.odd_par({CMD[15:10], cur_id, cur_rev});
                n_ok++;
            end else begin
                next_rsp = `SIDR_ERR_WORD;
                n_err++;
            end
        end
    endtask
    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        failures++;
        print_verdict();
    end
    initial begin
        {CORE_CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
        {AWADDR, ARADDR, WDATA} = '0;
        WSTRB = 4'hF;
        next_rsp = `SIDR_ERR_WORD;
        cur_id = `SIDR_ID_RST;
        cur_rev = `SIDR_REV_RST;
        en = 1'b1;
        lag = 1'b0;
        repeat (4) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        axi_rd(`SIDR_OFF_CTRL);
        `CHK("ctrl reset", `SIDR_CTRL_RST, rd)
        axi_rd(`SIDR_OFF_IDENT);
        `CHK("ident reset", {22'h0, cur_id, cur_rev}, rd)
        end_test("reset");
        frame(CMD, 1, 16, 5);
        frame(CMD, 1, 16, 9);
        frame(CMD, 0, 16, 5);
        frame(CMD, 1, 16, 5);
        frame(16'hC800, 1, 16, 5);
        frame(16'hCC01, 1, 16, 5);
        frame(CMD, 1, 16, 5);
        end_test("commands");
        foreach (VALS[i]) begin
            axi_wr(`SIDR_OFF_IDENT, VALS[i]);
            cur_id = VALS[i][9:6];
            cur_rev = VALS[i][5:0];
            axi_rd(`SIDR_OFF_IDENT);
            `CHK("ident readback", VALS[i], rd)
            frame(CMD, 1, 16, 5);
            frame(CMD, 1, 16, 5);
        end
        end_test("identity values");
        axi_wr(`SIDR_OFF_CTRL, 32'h0);
        en = 1'b0;
        frame(CMD, 1, 16, 5);
        frame(CMD, 1, 16, 5);
        axi_wr(`SIDR_OFF_CTRL, `SIDR_CTRL_RST);
        en = 1'b1;
        frame(CMD, 1, 16, 5);
        frame(CMD, 1, 15, 5);
        frame(CMD, 1, 16, 9);
        end_test("enable and short frame");
        axi_rd(`SIDR_OFF_LAST);
        `CHK("last word", {16'h0, u_master.odd_par(CMD)}, rd)
        axi_rd(`SIDR_OFF_STAT);
        `CHK("frame counts", {n_err[7:0], n_ok[15:0], 8'h00}, rd)
        // late ready lets the held-answer checks see a waiting master
        lag = 1'b1;
        axi_rd(4'h2);
        `CHK("unmapped read resp", `SIDR_RESP_SLVERR, rs)
        `CHK("unmapped read data", 32'h0, rd)
        axi_wr(4'h6, 32'hFFFF);
        `CHK("unmapped write resp", `SIDR_RESP_SLVERR, rs)
        lag = 1'b0;
        end_test("register bus");
        print_verdict();
    end
endmodule
`default_nettype wire
